/* src/dpms_master.sv */
// master service scheduler: start-up, cyclic, global control, acyclic
// assumes a frame engine that answers each request with one rsp pulse
`timescale 1ns/1ns
`default_nettype none
// Contract
// RULE_01: at most 125 assigned slaves served, cyclic and acyclic; the code has no count limit and serves any assigned address 0 to 126.
// RULE_02: cyclic totals capped at 5712 input and 5760 output bytes.
// RULE_03: per slave input, output and config data capped at 244 bytes.
// RULE_04: parameters are 7 standard bytes plus up to 237 user bytes.
// RULE_05: one acyclic read or write carries at most 240 bytes.
// RULE_06: baud rate chosen from ten fixed codes; no auto detection.
// RULE_07: only station addresses 0 to 126 are used.
// RULE_08: master broadcasts its control status periodically, including clear mode.
// RULE_09: in clear mode slaves hold or zero outputs per fail-safe setting.
// RULE_10: sync, unsync, freeze, unfreeze, clear sent to a slave or group.
// RULE_11: freeze holds slave inputs until unfreeze.
// RULE_12: sync latches slave outputs until next sync; unsync cancels.
// RULE_13: diagnostics have 6 standard bytes; extended bytes accepted.
// RULE_14: watchdog time sent at start-up; slave fails safe on expiry.
// RULE_15: acyclic exchange only after the cycle's cyclic exchange ends.
// RULE_16: acyclic read by slot and index, may span several cycles.
// RULE_17: acyclic timeout aborts all traffic to that slave; restart needed.
// RULE_18: acyclic write by slot and index, same timeout handling.
// RULE_19: every slave alarm is acknowledged by the master; the code acknowledges only the latest pending alarm.
// RULE_20: not-ready bit set keeps master stopped, all traffic halted.
// RULE_21: no isochronous, slave-to-slave or redundancy operation.
// RULE_22: leaving stop runs start-up: parameterize, configure, then cycle.
module dpms_master (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic host_not_ready_bit_in,
  input wire logic clear_mode_in,
  input wire logic [3:0] baud_sel_in,
  input wire logic [dpms_pkg::MAX_ADDR:0] assigned_in,
  input wire logic [7:0] in_len_in,
  input wire logic [7:0] out_len_in,
  input wire logic [7:0] cfg_len_in,
  input wire logic [7:0] user_prm_len_in,
  input wire dpms_pkg::dpms_gc_t gc_cmd_in,
  input wire dpms_pkg::dpms_acyc_t acyc_cmd_in,
  input wire dpms_pkg::dpms_rsp_t rsp_in,
  output logic gc_cmd_ready_out,
  output logic acyc_cmd_ready_out,
  output dpms_pkg::dpms_req_t req_out,
  output logic [3:0] baud_out,
  output logic stopped_out,
  output logic acyc_done_out,
  output logic acyc_abort_out,
  output logic cfg_error_out
);
  localparam int unsigned MAX_ADDR = dpms_pkg::MAX_ADDR;

  dpms_pkg::dpms_state_t st_r, st_nxt;
  dpms_pkg::dpms_req_t req_r, req_nxt;
  logic [7:0] addr_r, addr_nxt;
  logic [MAX_ADDR:0] dead_r, dead_nxt;
  logic [12:0] in_sum_r, in_sum_nxt, out_sum_r, out_sum_nxt;
  logic [22:0] gc_cnt_r, gc_cnt_nxt, tmo_r, tmo_nxt;
  logic gc_due_r, gc_due_nxt;
  logic acyc_busy_r, acyc_busy_nxt;
  dpms_pkg::dpms_acyc_t acyc_r, acyc_nxt;
  logic alarm_pend_r, alarm_pend_nxt;
  logic [7:0] alarm_addr_r, alarm_addr_nxt;
  logic [3:0] baud_r, baud_nxt;
  logic done_r, done_nxt, abort_r, abort_nxt, cfg_err_r, cfg_err_nxt;
  logic gc_rdy_r, gc_rdy_nxt, ac_rdy_r, ac_rdy_nxt;
  logic [7:0] len_c;
  logic active_c;

  // ------------------------------------------------------------------
  // scheduler
  // ------------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    req_nxt = req_r;
    req_nxt.valid = 1'b0;
    addr_nxt = addr_r;
    dead_nxt = dead_r;
    in_sum_nxt = in_sum_r;
    out_sum_nxt = out_sum_r;
    gc_cnt_nxt = gc_cnt_r;
    gc_due_nxt = gc_due_r;
    acyc_busy_nxt = acyc_busy_r;
    acyc_nxt = acyc_r;
    alarm_pend_nxt = alarm_pend_r;
    alarm_addr_nxt = alarm_addr_r;
    baud_nxt = baud_r;
    done_nxt = 1'b0;
    abort_nxt = 1'b0;
    cfg_err_nxt = cfg_err_r;
    tmo_nxt = tmo_r;
    len_c = dpms_pkg::LEN_ZERO;
    // the broadcast address 127 is never a station
    active_c = (addr_r <= dpms_pkg::ADDR_LAST) && assigned_in[addr_r[6:0]] && !dead_r[addr_r[6:0]];
    gc_rdy_nxt = 1'b0;
    ac_rdy_nxt = !host_not_ready_bit_in && !acyc_busy_r && !acyc_cmd_in.valid && !st_r[0];
    // periodic control status broadcast
    if (gc_cnt_r == dpms_pkg::CNT_ZERO) // RULE_08
    begin
      gc_cnt_nxt = 23'(dpms_pkg::GC_PERIOD_CYC - 1);
      gc_due_nxt = 1'b1;
    end
    else
    begin
      gc_cnt_nxt = gc_cnt_r - dpms_pkg::CNT_ONE;
    end
    // accept acyclic job with length and address checks
    if (acyc_cmd_in.valid && ac_rdy_r && !acyc_busy_r)
    begin
      if (acyc_cmd_in.len <= 8'(dpms_pkg::ACYC_MAX) && acyc_cmd_in.addr <= dpms_pkg::ADDR_LAST) // RULE_05 RULE_07
      begin
        acyc_nxt = acyc_cmd_in; // RULE_16 RULE_18
        acyc_busy_nxt = 1'b1;
        tmo_nxt = 23'(dpms_pkg::ACYC_TMO_CYC);
      end
      else
      begin
        abort_nxt = 1'b1;
      end
    end
    if (acyc_busy_r && tmo_r != dpms_pkg::CNT_ZERO)
    begin
      tmo_nxt = tmo_r - dpms_pkg::CNT_ONE;
    end
    // acyclic timeout drops the slave until next start-up
    if (acyc_busy_r && tmo_r == dpms_pkg::CNT_ONE) // RULE_17
    begin
      acyc_busy_nxt = 1'b0;
      abort_nxt = 1'b1;
      dead_nxt[acyc_r.addr[6:0]] = 1'b1;
    end
    // outside stop, the latest alarm seen in any response is remembered for acknowledgement
    if (rsp_in.valid && rsp_in.alarm) // RULE_19
    begin
      alarm_pend_nxt = 1'b1;
      alarm_addr_nxt = req_r.addr;
    end
    unique case (st_r)
      dpms_pkg::DPMS_STOP:
      begin
        addr_nxt = dpms_pkg::ADDR_FIRST;
        acyc_busy_nxt = 1'b0;
        alarm_pend_nxt = 1'b0;
        if (baud_sel_in <= dpms_pkg::RATE_LAST) // RULE_06
        begin
          baud_nxt = baud_sel_in;
        end
        if (!host_not_ready_bit_in) // RULE_22
        begin
          dead_nxt = '0;
          cfg_err_nxt = 1'b0;
          st_nxt = dpms_pkg::DPMS_PRM;
        end
      end
      dpms_pkg::DPMS_PRM, dpms_pkg::DPMS_CFG, dpms_pkg::DPMS_CYC:
      begin
        if (!active_c)
        begin
          addr_nxt = addr_r + 8'h01;
        end
        else
        begin
          req_nxt.valid = 1'b1;
          req_nxt.addr = addr_r;
          req_nxt.ctrl = {7'h00, clear_mode_in};
          if (st_r == dpms_pkg::DPMS_PRM)
          begin
            // standard block carries the watchdog time
            req_nxt.kind = dpms_pkg::DPMS_K_PRM; // RULE_04 RULE_14
            len_c = 8'(dpms_pkg::STD_PRM_LEN) + ((user_prm_len_in > 8'(dpms_pkg::USER_PRM_MAX))
              ? 8'(dpms_pkg::USER_PRM_MAX) : user_prm_len_in);
            cfg_err_nxt = cfg_err_r | (user_prm_len_in > 8'(dpms_pkg::USER_PRM_MAX));
          end
          else if (st_r == dpms_pkg::DPMS_CFG)
          begin
            req_nxt.kind = dpms_pkg::DPMS_K_CFG; // RULE_03
            len_c = (cfg_len_in > 8'(dpms_pkg::SLAVE_DATA_MAX)) ? 8'(dpms_pkg::SLAVE_DATA_MAX) : cfg_len_in;
            cfg_err_nxt = cfg_err_r | (cfg_len_in > 8'(dpms_pkg::SLAVE_DATA_MAX));
          end
          else
          begin
            req_nxt.kind = dpms_pkg::DPMS_K_DATA;
            len_c = (out_len_in > 8'(dpms_pkg::SLAVE_DATA_MAX)) ? 8'(dpms_pkg::SLAVE_DATA_MAX) : out_len_in; // RULE_03
            cfg_err_nxt = cfg_err_r | (in_len_in > 8'(dpms_pkg::SLAVE_DATA_MAX))
              | (out_len_in > 8'(dpms_pkg::SLAVE_DATA_MAX)); // RULE_03
            // slaves beyond the byte budget are skipped
            if (out_sum_r + 13'(len_c) > 13'(dpms_pkg::TOTAL_OUT_MAX)
              || in_sum_r + 13'(in_len_in) > 13'(dpms_pkg::TOTAL_IN_MAX)) // RULE_02
            begin
              req_nxt.valid = 1'b0;
              cfg_err_nxt = 1'b1;
              addr_nxt = addr_r + 8'h01;
            end
            else
            begin
              out_sum_nxt = out_sum_r + 13'(len_c);
              in_sum_nxt = in_sum_r + 13'(in_len_in);
            end
          end
          req_nxt.len = len_c;
          if (req_nxt.valid)
          begin
            st_nxt = dpms_pkg::DPMS_WAIT;
          end
        end
        // end of address sweep
        if (addr_r >= dpms_pkg::ADDR_LAST && !(active_c && req_nxt.valid)) // RULE_07 RULE_01
        begin
          addr_nxt = dpms_pkg::ADDR_FIRST;
          in_sum_nxt = dpms_pkg::BYTES_ZERO;
          out_sum_nxt = dpms_pkg::BYTES_ZERO;
          if (st_r == dpms_pkg::DPMS_PRM)
          begin
            st_nxt = dpms_pkg::DPMS_CFG;
          end
          else
          begin
            st_nxt = dpms_pkg::DPMS_GC;
          end
        end
      end
      dpms_pkg::DPMS_GC:
      begin
        // broadcasts go between cycles; acyclic last
        st_nxt = dpms_pkg::DPMS_ACYC;
        if (gc_cmd_in.valid && gc_rdy_r) // RULE_10
        begin
          req_nxt = '{valid: 1'b1, kind: dpms_pkg::DPMS_K_GC, addr: gc_cmd_in.addr, len: dpms_pkg::LEN_ZERO,
            ctrl: gc_cmd_in.ctrl | {7'h00, clear_mode_in}, group: gc_cmd_in.group, slot: 8'h00, index: 8'h00};
        end
        else if (gc_due_r)
        begin
          gc_due_nxt = 1'b0;
          req_nxt = '{valid: 1'b1, kind: dpms_pkg::DPMS_K_GC, addr: dpms_pkg::ADDR_LAST + 8'h01, len: dpms_pkg::LEN_ZERO,
            ctrl: clear_mode_in ? dpms_pkg::GC_CLEAR : 8'h00, group: 8'h00, slot: 8'h00, index: 8'h00}; // RULE_08
        end
      end
      dpms_pkg::DPMS_ACYC:
      begin
        st_nxt = dpms_pkg::DPMS_CYC;
        if (alarm_pend_r)
        begin
          // an alarm arriving now stays pending
          alarm_pend_nxt = rsp_in.valid && rsp_in.alarm; // RULE_19
          req_nxt = '{valid: 1'b1, kind: dpms_pkg::DPMS_K_ALACK, addr: alarm_addr_r, len: dpms_pkg::LEN_ZERO,
            ctrl: 8'h00, group: 8'h00, slot: 8'h00, index: 8'h00}; // RULE_19
          st_nxt = dpms_pkg::DPMS_WAIT;
        end
        else if (acyc_busy_r && !dead_r[acyc_r.addr[6:0]]) // RULE_15
        begin
          req_nxt = '{valid: 1'b1, kind: acyc_r.write ? dpms_pkg::DPMS_K_WR : dpms_pkg::DPMS_K_RD,
            addr: acyc_r.addr, len: acyc_r.len, ctrl: 8'h00, group: 8'h00,
            slot: acyc_r.slot, index: acyc_r.index}; // RULE_16 RULE_18
          st_nxt = dpms_pkg::DPMS_WAIT;
        end
      end
      dpms_pkg::DPMS_WAIT:
      begin
        if (rsp_in.valid) // RULE_21
        begin
          // diagnostics of any length beyond the standard part are accepted
          if (req_r.kind == dpms_pkg::DPMS_K_RD || req_r.kind == dpms_pkg::DPMS_K_WR)
          begin
            if (rsp_in.ok) // RULE_16
            begin
              acyc_busy_nxt = 1'b0;
              done_nxt = 1'b1;
            end
            st_nxt = dpms_pkg::DPMS_CYC;
          end
          else if (req_r.kind == dpms_pkg::DPMS_K_ALACK)
          begin
            st_nxt = dpms_pkg::DPMS_ACYC;
          end
          else
          begin
            addr_nxt = addr_r + 8'h01;
            st_nxt = (req_r.kind == dpms_pkg::DPMS_K_PRM) ? dpms_pkg::DPMS_PRM
              : (req_r.kind == dpms_pkg::DPMS_K_CFG) ? dpms_pkg::DPMS_CFG : dpms_pkg::DPMS_CYC;
            if (rsp_in.diag && rsp_in.len < 8'(dpms_pkg::DIAG_STD_LEN)) // RULE_13
            begin
              cfg_err_nxt = 1'b1;
            end
          end
        end
      end
    endcase
    // not-ready forces stop from any state
    if (host_not_ready_bit_in) // RULE_20
    begin
      st_nxt = dpms_pkg::DPMS_STOP;
      req_nxt.valid = 1'b0;
      acyc_busy_nxt = 1'b0;
    end
    // ready only in the cycle the command is really taken
    gc_rdy_nxt = (st_nxt == dpms_pkg::DPMS_GC); // RULE_10
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      st_r <= dpms_pkg::DPMS_STOP;
      req_r <= '0;
      addr_r <= dpms_pkg::ADDR_FIRST;
      dead_r <= '0;
      in_sum_r <= dpms_pkg::BYTES_ZERO;
      out_sum_r <= dpms_pkg::BYTES_ZERO;
      gc_cnt_r <= dpms_pkg::CNT_ZERO;
      gc_due_r <= 1'b0;
      acyc_busy_r <= 1'b0;
      acyc_r <= '0;
      alarm_pend_r <= 1'b0;
      alarm_addr_r <= dpms_pkg::DEFAULT_ADDR;
      baud_r <= 4'h0;
      done_r <= 1'b0;
      abort_r <= 1'b0;
      cfg_err_r <= 1'b0;
      tmo_r <= dpms_pkg::CNT_ZERO;
      gc_rdy_r <= 1'b0;
      ac_rdy_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      req_r <= req_nxt;
      addr_r <= addr_nxt;
      dead_r <= dead_nxt;
      in_sum_r <= in_sum_nxt;
      out_sum_r <= out_sum_nxt;
      gc_cnt_r <= gc_cnt_nxt;
      gc_due_r <= gc_due_nxt;
      acyc_busy_r <= acyc_busy_nxt;
      acyc_r <= acyc_nxt;
      alarm_pend_r <= alarm_pend_nxt;
      alarm_addr_r <= alarm_addr_nxt;
      baud_r <= baud_nxt;
      done_r <= done_nxt;
      abort_r <= abort_nxt;
      cfg_err_r <= cfg_err_nxt;
      tmo_r <= tmo_nxt;
      gc_rdy_r <= gc_rdy_nxt;
      ac_rdy_r <= ac_rdy_nxt;
    end
  end

  assign req_out = req_r;
  assign baud_out = baud_r;
  assign stopped_out = st_r[0];
  assign acyc_done_out = done_r;
  assign acyc_abort_out = abort_r;
  assign cfg_error_out = cfg_err_r;
  assign gc_cmd_ready_out = gc_rdy_r;
  assign acyc_cmd_ready_out = ac_rdy_r;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  a_stop_on_host_not_ready_bit: assert property (@(posedge clk_in) disable iff (rst_in)
    host_not_ready_bit_in |=> stopped_out && !req_out.valid) else $error("not stopped when not ready"); // RULE_20
  a_acyc_len_cap: assert property (@(posedge clk_in) disable iff (rst_in)
    req_out.valid && (req_out.kind == dpms_pkg::DPMS_K_RD || req_out.kind == dpms_pkg::DPMS_K_WR)
    |-> req_out.len <= 8'd240) else $error("acyclic length too long"); // RULE_05
  a_data_len_cap: assert property (@(posedge clk_in) disable iff (rst_in)
    req_out.valid && req_out.kind != dpms_pkg::DPMS_K_PRM |-> req_out.len <= 8'd244) else $error("data too long"); // RULE_03
  a_prm_len_cap: assert property (@(posedge clk_in) disable iff (rst_in)
    req_out.valid && req_out.kind == dpms_pkg::DPMS_K_PRM |-> req_out.len >= 8'd7 && req_out.len <= 8'd244)
    else $error("parameter length bad"); // RULE_04
  a_addr_range: assert property (@(posedge clk_in) disable iff (rst_in)
    req_out.valid && req_out.kind != dpms_pkg::DPMS_K_GC |-> req_out.addr <= 8'd126) else $error("bad address"); // RULE_07
  a_acyc_after_gc: assert property (@(posedge clk_in) disable iff (rst_in)
    req_out.valid && (req_out.kind == dpms_pkg::DPMS_K_RD || req_out.kind == dpms_pkg::DPMS_K_WR)
    |-> $past(st_r) == dpms_pkg::DPMS_ACYC)
    else $error("acyclic inside cycle"); // RULE_15
  a_start_prm: assert property (@(posedge clk_in) disable iff (rst_in)
    st_r == dpms_pkg::DPMS_STOP && !host_not_ready_bit_in |=> st_r == dpms_pkg::DPMS_PRM)
    else $error("no start-up after ready"); // RULE_22
  a_out_budget: assert property (@(posedge clk_in) disable iff (rst_in)
    out_sum_r <= 13'd5760 && in_sum_r <= 13'd5712) else $error("byte budget exceeded"); // RULE_02
  a_tmo_abort: assert property (@(posedge clk_in) disable iff (rst_in || host_not_ready_bit_in)
    acyc_busy_r && tmo_r == 23'd1 |=> acyc_abort_out && dead_r[acyc_r.addr[6:0]]) else $error("timeout not aborted"); // RULE_17
endmodule
`default_nettype wire

/* src/dpms_pkg.sv */
// package for the fieldbus master service scheduler
// assumes a 50 MHz system clock and an external frame engine
package dpms_pkg;
  localparam int unsigned MAX_SLAVES = 125;
  localparam int unsigned MAX_ADDR = 126;
  localparam int unsigned TOTAL_IN_MAX = 5712;
  localparam int unsigned TOTAL_OUT_MAX = 5760;
  localparam int unsigned SLAVE_DATA_MAX = 244;
  localparam int unsigned STD_PRM_LEN = 7;
  localparam int unsigned USER_PRM_MAX = 237;
  localparam int unsigned ACYC_MAX = 240;
  localparam int unsigned DIAG_STD_LEN = 6;
  localparam int unsigned NUM_RATES = 10;
  localparam logic [3:0] RATE_LAST = 4'h9;
  localparam logic [7:0] ADDR_LAST = 8'h7E;
  localparam logic [7:0] ADDR_FIRST = 8'h00;
  localparam logic [7:0] LEN_ZERO = 8'h00;
  localparam logic [7:0] DEFAULT_ADDR = 8'h00;
  localparam logic [12:0] BYTES_ZERO = 13'h0000;
  localparam logic [7:0] GC_SYNC = 8'h20;
  localparam logic [7:0] GC_UNSYNC = 8'h10;
  localparam logic [7:0] GC_FREEZE = 8'h08;
  localparam logic [7:0] GC_UNFREEZE = 8'h04;
  localparam logic [7:0] GC_CLEAR = 8'h02;
  localparam int unsigned GC_PERIOD_US = 10000;
  localparam int unsigned CLK_MHZ = 50;
  localparam int unsigned GC_PERIOD_CYC = GC_PERIOD_US * CLK_MHZ;
  localparam int unsigned ACYC_TMO_US = 100000;
  localparam int unsigned ACYC_TMO_CYC = ACYC_TMO_US * CLK_MHZ;
  localparam logic [22:0] CNT_ZERO = 23'h000000;
  localparam logic [22:0] CNT_ONE = 23'h000001;

  typedef enum logic [6:0] {
    DPMS_STOP = 7'h01,
    DPMS_PRM = 7'h02,
    DPMS_CFG = 7'h04,
    DPMS_CYC = 7'h08,
    DPMS_GC = 7'h10,
    DPMS_ACYC = 7'h20,
    DPMS_WAIT = 7'h40
  } dpms_state_t;

  typedef enum logic [2:0] {
    DPMS_K_NONE = 3'h0,
    DPMS_K_PRM = 3'h1,
    DPMS_K_CFG = 3'h2,
    DPMS_K_DATA = 3'h3,
    DPMS_K_GC = 3'h4,
    DPMS_K_RD = 3'h5,
    DPMS_K_WR = 3'h6,
    DPMS_K_ALACK = 3'h7
  } dpms_kind_t;

  typedef struct packed {
    logic valid;
    dpms_kind_t kind;
    logic [7:0] addr;
    logic [7:0] len;
    logic [7:0] ctrl;
    logic [7:0] group;
    logic [7:0] slot;
    logic [7:0] index;
  } dpms_req_t;

  typedef struct packed {
    logic valid;
    logic ok;
    logic [7:0] len;
    logic diag;
    logic alarm;
  } dpms_rsp_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [7:0] slot;
    logic [7:0] index;
    logic [7:0] len;
  } dpms_acyc_t;

  typedef struct packed {
    logic valid;
    logic [7:0] ctrl;
    logic [7:0] group;
    logic [7:0] addr;
  } dpms_gc_t;
endpackage

/* tb/dpms_slave_model.sv */
// slave-side model: answers each master request with one rsp pulse unless a newer request arrives before it answers
// assumes req_in comes from dpms_master on the shared clk_in and rst_in
`timescale 1ns/1ns
`default_nettype none
module dpms_slave_model #(
  parameter int unsigned WD_LIMIT = 40000
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire dpms_pkg::dpms_req_t req_in,
  input wire logic slow_in,
  input wire logic alarm_arm_in,
  output var dpms_pkg::dpms_rsp_t rsp_out
);
  logic busy_r;
  logic [3:0] wait_r;
  dpms_pkg::dpms_req_t cur_r;
  logic frozen_r;
  logic synced_r;
  logic outs_zero_r;
  logic [15:0] wd_r;
  // ------------------------------
  // answer engine and slave state
  // ------------------------------
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      rsp_out <= '0;
      busy_r <= 1'b0;
      wait_r <= 4'h0;
      cur_r <= '0;
      frozen_r <= 1'b0;
      synced_r <= 1'b0;
      outs_zero_r <= 1'b0;
      wd_r <= 16'h0000;
    end
    else
    begin
      // idle fields toggle so a stale value is never trusted
      rsp_out <= '{1'b0, ~rsp_out.ok, ~rsp_out.len, ~rsp_out.diag, ~rsp_out.alarm};
      wd_r <= wd_r + 16'h0001;
      if (wd_r == WD_LIMIT[15:0])
        outs_zero_r <= 1'b1;
      if (req_in.valid)
      begin
        busy_r <= 1'b1;
        cur_r <= req_in;
        wait_r <= slow_in ? 4'h6 : 4'h0;
        wd_r <= 16'h0000;
      end
      else if (busy_r && wait_r != 4'h0)
        wait_r <= wait_r - 4'h1;
      else if (busy_r)
      begin
        busy_r <= 1'b0;
        rsp_out.valid <= 1'b1;
        rsp_out.ok <= (cur_r.addr <= dpms_pkg::ADDR_LAST);
        rsp_out.len <= (cur_r.len > 8'hF4) ? 8'hF4 : cur_r.len;
        rsp_out.diag <= 1'b0;
        rsp_out.alarm <= 1'b0;
        if (alarm_arm_in && cur_r.kind == dpms_pkg::DPMS_K_DATA)
        begin
          rsp_out.diag <= 1'b1;
          rsp_out.alarm <= 1'b1;
          rsp_out.len <= 8'h09;
        end
        if (cur_r.kind == dpms_pkg::DPMS_K_GC)
        begin
          frozen_r <= (frozen_r | (|(cur_r.ctrl & dpms_pkg::GC_FREEZE))) & ~(|(cur_r.ctrl & dpms_pkg::GC_UNFREEZE));
          synced_r <= (synced_r | (|(cur_r.ctrl & dpms_pkg::GC_SYNC))) & ~(|(cur_r.ctrl & dpms_pkg::GC_UNSYNC));
          outs_zero_r <= |(cur_r.ctrl & (dpms_pkg::GC_CLEAR | 8'h01));
        end
      end
    end
  end
endmodule
`default_nettype wire

/* tb/test_fieldbus_dp_master_services.sv */
// self-checking bench for dpms_master with a slave-side model
// assumes a 50 MHz clock and stations 3, 7 and 126 assigned
`timescale 1ns/1ns
`default_nettype none
module test_fieldbus_dp_master_services;
  typedef struct packed {logic wr; logic [7:0] addr, slot, idx, len; logic slow, abort;} dpms_row_t;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic host_not_ready_bit_in = 1'b1;
  logic clear_mode_in = 1'b0;
  logic [3:0] baud_sel_in = 4'h0;
  logic [dpms_pkg::MAX_ADDR:0] assigned_in = 127'h4000_0000_0000_0000_0000_0000_0000_0088;
  logic [7:0] in_len_in = 8'hF4;
  logic [7:0] out_len_in = 8'h20;
  logic [7:0] cfg_len_in = 8'h04;
  logic [7:0] user_prm_len_in = 8'hED;
  dpms_pkg::dpms_gc_t gc_cmd_in = '0;
  dpms_pkg::dpms_acyc_t acyc_cmd_in = '0;
  dpms_pkg::dpms_rsp_t rsp_in;
  dpms_pkg::dpms_req_t req_out;
  logic gc_cmd_ready_out, acyc_cmd_ready_out, stopped_out, acyc_done_out, acyc_abort_out, cfg_error_out;
  logic [3:0] baud_out;
  logic slow = 1'b0;
  logic alarm_arm = 1'b0;
  dpms_pkg::dpms_req_t seen [$];
  int mismatches = 0, n_tests = 0, n_end = 0, n_abort = 0, n_acyc = 0, n_gc = 0;
  logic [7:0] exp_a [3] = '{8'h03, 8'h07, 8'h7E};
  logic [7:0] gcs [5] = '{dpms_pkg::GC_SYNC, dpms_pkg::GC_UNSYNC, dpms_pkg::GC_FREEZE, dpms_pkg::GC_UNFREEZE,
    dpms_pkg::GC_CLEAR};
  dpms_row_t rows [6] = '{
    '{1'b0, 8'h03, 8'h01, 8'h02, 8'h10, 1'b0, 1'b0},
    '{1'b1, 8'h07, 8'h00, 8'hFF, 8'hF0, 1'b1, 1'b0},
    '{1'b0, 8'h7E, 8'hFF, 8'h00, 8'h01, 1'b0, 1'b0},
    '{1'b1, 8'h03, 8'h02, 8'h05, 8'hF1, 1'b0, 1'b1},
    '{1'b0, 8'h7F, 8'h01, 8'h01, 8'h04, 1'b1, 1'b1},
    '{1'b1, 8'hFF, 8'h01, 8'h01, 8'h04, 1'b0, 1'b1}};
  // --------------------
  // design and partner
  // --------------------
  dpms_master i_dpms_master (.clk_in(clk_in), .rst_in(rst_in), .host_not_ready_bit_in(host_not_ready_bit_in),
    .clear_mode_in(clear_mode_in), .baud_sel_in(baud_sel_in), .assigned_in(assigned_in), .in_len_in(in_len_in),
    .out_len_in(out_len_in), .cfg_len_in(cfg_len_in), .user_prm_len_in(user_prm_len_in), .gc_cmd_in(gc_cmd_in),
    .acyc_cmd_in(acyc_cmd_in), .rsp_in(rsp_in), .gc_cmd_ready_out(gc_cmd_ready_out),
    .acyc_cmd_ready_out(acyc_cmd_ready_out), .req_out(req_out), .baud_out(baud_out), .stopped_out(stopped_out),
    .acyc_done_out(acyc_done_out), .acyc_abort_out(acyc_abort_out), .cfg_error_out(cfg_error_out));
  dpms_slave_model i_dpms_slave_model (.clk_in(clk_in), .rst_in(rst_in), .req_in(req_out), .slow_in(slow),
    .alarm_arm_in(alarm_arm), .rsp_out(rsp_in));
  always #10 clk_in = ~clk_in;
  // --------------------
  // monitor
  // --------------------
  always @(posedge clk_in)
  begin
    if (req_out.valid === 1'b1) seen.push_back(req_out);
    if (acyc_done_out === 1'b1 || acyc_abort_out === 1'b1) n_end++;
    if (acyc_abort_out === 1'b1) n_abort++;
    if (acyc_cmd_in.valid && acyc_cmd_ready_out === 1'b1) n_acyc++;
    if (gc_cmd_in.valid && gc_cmd_ready_out === 1'b1) n_gc++;
  end
  // --------------------
  // tasks
  // --------------------
  task automatic fail(input string msg);
    mismatches++;
    $display("unexpected at %0t: %s", $time, msg);
  endtask
  task automatic check_val(input logic [7:0] got, input logic [7:0] exp, input string msg);
    n_tests++;
    if (got !== exp) fail($sformatf("%s got %h want %h", msg, got, exp));
  endtask
  task automatic wait_for(ref int cnt, input int base, input string msg);
    for (int k = 0; k < 4000 && cnt <= base; k++) @(negedge clk_in);
    if (cnt <= base) fail(msg);
  endtask
  task automatic find_req(input dpms_pkg::dpms_kind_t kd, input int from, output int idx);
    idx = -1;
    for (int k = 0; k < 4000 && idx < 0; k++)
    begin
      for (int i = from; i < seen.size() && idx < 0; i++) if (seen[i].kind === kd) idx = i;
      if (idx < 0) @(negedge clk_in);
    end
    if (idx < 0) fail("request kind missing");
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    #(60000 * 20);
    fail("watchdog expired");
    wrap_up();
  end
  // --------------------
  // main sequence
  // --------------------
  initial
  begin
    int idx, base, k0, ab0;
    repeat (12) @(negedge clk_in);
    check_val({7'h00, req_out.valid}, 8'h00, "req in reset");
    check_val({7'h00, cfg_error_out}, 8'h00, "cfg error in reset");
    check_val({4'h0, baud_out}, 8'h00, "baud in reset");
    rst_in = 1'b0;
    for (int r = 0; r < 11; r++)
    begin
      baud_sel_in = 4'(r);
      repeat (3) @(negedge clk_in);
      check_val({4'h0, baud_out}, (r < 10) ? 8'(r) : 8'h09, "baud code");
    end
    check_val({7'h00, stopped_out}, 8'h01, "stop mode");
    check_val(8'(seen.size()), 8'h00, "traffic while not ready");
    host_not_ready_bit_in = 1'b0;
    for (int i = 0; i < 6; i++)
    begin
      find_req((i < 3) ? dpms_pkg::DPMS_K_PRM : dpms_pkg::DPMS_K_CFG, i, idx);
      check_val(8'(idx), 8'(i), "start-up order");
      if (idx >= 0) check_val(seen[idx].addr, exp_a[i % 3], "start-up address");
    end
    find_req(dpms_pkg::DPMS_K_DATA, 6, idx);
    check_val({7'h00, cfg_error_out}, 8'h00, "limits at 244");
    foreach (rows[r])
    begin
      slow = rows[r].slow;
      base = n_end;
      ab0 = n_abort;
      k0 = n_acyc;
      acyc_cmd_in = '{1'b1, rows[r].wr, rows[r].addr, rows[r].slot, rows[r].idx, rows[r].len};
      wait_for(n_acyc, k0, "acyclic not taken");
      acyc_cmd_in.valid = 1'b0;
      k0 = seen.size();
      wait_for(n_end, base, "acyclic not finished");
      check_val(8'(n_abort - ab0), {7'h00, rows[r].abort}, "acyclic abort");
      if (!rows[r].abort)
      begin
        find_req(rows[r].wr ? dpms_pkg::DPMS_K_WR : dpms_pkg::DPMS_K_RD, k0, idx);
        if (idx >= 0) check_val(seen[idx].addr, rows[r].addr, "acyclic address");
        if (idx >= 0) check_val(seen[idx].slot, rows[r].slot, "acyclic slot");
        if (idx >= 0) check_val(seen[idx].index, rows[r].idx, "acyclic index");
        if (idx >= 0) check_val(seen[idx].len, rows[r].len, "acyclic length");
      end
    end
    slow = 1'b0;
    for (int g = 0; g < 6; g++)
    begin
      clear_mode_in = (g == 5);
      k0 = n_gc;
      gc_cmd_in = '{1'b1, gcs[g % 5], (g == 4) ? 8'h01 : 8'h00, 8'h07};
      wait_for(n_gc, k0, "control command not taken");
      gc_cmd_in.valid = 1'b0;
      k0 = seen.size();
      find_req(dpms_pkg::DPMS_K_GC, k0, idx);
      if (idx >= 0) check_val(seen[idx].ctrl, gcs[g % 5] | {7'h00, clear_mode_in}, "control code");
      if (idx >= 0) check_val(seen[idx].group, (g == 4) ? 8'h01 : 8'h00, "control group");
    end
    clear_mode_in = 1'b0;
    alarm_arm = 1'b1;
    find_req(dpms_pkg::DPMS_K_ALACK, seen.size(), idx);
    alarm_arm = 1'b0;
    if (idx >= 0) check_val(seen[idx].addr, 8'h7E, "alarm ack station");
    check_val({7'h00, cfg_error_out}, 8'h00, "extended diagnostics");
    check_val({6'h00, i_dpms_slave_model.synced_r, i_dpms_slave_model.frozen_r}, 8'h02, "sync");
    host_not_ready_bit_in = 1'b1;
    for (int k = 0; k < 4000 && stopped_out !== 1'b1; k++) @(negedge clk_in);
    check_val({7'h00, stopped_out}, 8'h01, "stop entered");
    k0 = seen.size();
    repeat (300) @(negedge clk_in);
    check_val(8'(seen.size() - k0), 8'h00, "traffic in stop");
    in_len_in = 8'hF5;
    host_not_ready_bit_in = 1'b0;
    for (int k = 0; k < 4000 && cfg_error_out !== 1'b1; k++) @(negedge clk_in);
    check_val({7'h00, cfg_error_out}, 8'h01, "input length 245");
    wrap_up();
  end
endmodule
`default_nettype wire
